// ==== rtl/hpm_consts.svh ====
`ifndef HPM_CONSTS_SVH
`define HPM_CONSTS_SVH
`define HPM_OPC_STOP 8'h8e
`define HPM_IMASK_STOP 2'h2
`define HPM_IMASK_RESET 2'h3
`define HPM_HSIZE_WORD 3'h2
`define HPM_STAB_SHORT 13'h0100
`define HPM_STAB_LONG 13'h1000
`define HPM_A_CTRL 32'h0000_0000
`define HPM_A_STATUS 32'h0000_0004
`define HPM_A_CCR 32'h0000_0008
`define HPM_A_IRQ 32'h0000_000c
`define HPM_ADDR_W 4
`define HPM_CTRL_OIE 0
`define HPM_CTRL_LONG 1
`define HPM_CTRL_WDGS 2
`define HPM_CTRL_WDGEN 3
`endif

// ==== rtl/hpm_pkg.sv ====
package hpm_pkg;
    typedef enum logic [2:0] {
        HPM_RUN = 3'b000,
        HPM_ACTIVE_STOP = 3'b001,
        HPM_FULL_STOP = 3'b010,
        HPM_STABILISE = 3'b011,
        HPM_RESUME = 3'b100
    } hpm_state_t;
    typedef enum logic [1:0] {
        HPM_WAKE_NONE = 2'b00,
        HPM_WAKE_IRQ = 2'b01,
        HPM_WAKE_RESET = 2'b10
    } hpm_wake_t;
endpackage

// ==== rtl/hpm_stab_timer.sv ====
`include "hpm_consts.svh"

// Down-counter for the oscillator stabilisation wait.
module hpm_stab_timer #(
    parameter int WIDTH = 13
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [WIDTH-1:0] length,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= length;
            end else if (count != '0) begin
                count <= count - 1'b1;
                if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    done <= 1'b1;
                end
            end
        end
    end

    assign busy = (count != '0);
endmodule

// ==== rtl/hpm_ctrl.sv ====
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`include "hpm_consts.svh"

// How it works
// RQ1: Stop with enable set enters clocked stop.
// RQ2: Stop with enable clear enters full stop.
// RQ3: Clocked stop left by counter irq/reset.
// RQ4: Counter wake from clocked stop: no wait.
// RQ5: Reset wake from clocked stop: full wait.
// RQ6: Entering stop forces priority mask to 10.
// RQ7: Pending interrupt at entry wakes at once.
// RQ8: Clocked stop: only oscillator, counter clocked.
// RQ9: Clocked stop never causes watchdog reset.
// RQ10: Software keeps enable set during wait.
// RQ11: Wait is 256 or 4096 cycles, option.
// RQ12: Full stop left by reset/designated interrupts.
// RQ13: Full stop wake restarts oscillator, waits.
// RQ14: Resume via interrupt or reset vector.
// RQ15: Full stop turns main oscillator off.
// RQ16: Full stop watchdog reset per option bit.
// RQ17: Irq service pushes and sets priority mask.
// RQ18: Opcode 8e is the stop instruction.
// RQ19: Software re-arms wake pin before stop.
// RQ20: Software may clear pending flags first.
// RQ21: Reset wins over simultaneous interrupt.
module hpm_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] opcode,
    input wire logic opcode_valid,
    input wire logic rt_counter_irq,
    input wire logic wake_irq,
    input wire logic other_irq,
    input wire logic wake_reset_req,
    input wire logic [7:0] condition_code_reg,
    input wire logic [1:0] irq_level,
    input wire logic irq_taken,
    output logic cpu_halt,
    output logic osc_enable,
    output logic rt_counter_clk_en,
    output logic periph_clk_en,
    output logic cc_force,
    output logic [7:0] cc_force_value,
    output logic cc_push,
    output logic [1:0] irq_priority_mask,
    output logic resume_irq,
    output logic resume_reset_vector,
    output logic watchdog_reset
);
    hpm_pkg::hpm_state_t state, next_state;
    hpm_pkg::hpm_wake_t wake_cause;
    logic osc_irq_enable, long_stab, watchdog_in_stop_option, wdg_enabled;
    logic [7:0] main_clock_status_reg;
    logic [7:0] cc_shadow;
    logic stab_start, stab_busy, stab_done;
    logic [12:0] stab_len;
    logic stop_exec, irq_pend_sync1, irq_pend_sync2, wake_sync1, wake_sync2;
    logic rt_sync1, rt_sync2, rst_sync1, rst_sync2, oth_sync1, oth_sync2;
    logic wr_pend, bus_ok;
    logic [`HPM_ADDR_W-1:0] a_reg;
    localparam logic [1:0] IMASK_STOP = `HPM_IMASK_STOP;

    ////////////////////////////////////////////////////////////////////////
    // Wake sources come from other clocks, so each gets two flops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_sync1 <= 1'b0;
            rt_sync2 <= 1'b0;
            wake_sync1 <= 1'b0;
            wake_sync2 <= 1'b0;
            oth_sync1 <= 1'b0;
            oth_sync2 <= 1'b0;
            rst_sync1 <= 1'b0;
            rst_sync2 <= 1'b0;
        end else begin
            rt_sync1 <= rt_counter_irq;
            rt_sync2 <= rt_sync1;
            wake_sync1 <= wake_irq;
            wake_sync2 <= wake_sync1;
            oth_sync1 <= other_irq;
            oth_sync2 <= oth_sync1;
            rst_sync1 <= wake_reset_req;
            rst_sync2 <= rst_sync1;
        end
    end

    assign irq_pend_sync1 = rt_sync2 | wake_sync2 | oth_sync2;
    assign irq_pend_sync2 = irq_pend_sync1;
    // RQ18: stop opcode decode
    assign stop_exec = opcode_valid && (opcode == `HPM_OPC_STOP);

    ////////////////////////////////////////////////////////////////////////
    // RQ11: wait length option
    assign stab_len = long_stab ? `HPM_STAB_LONG : `HPM_STAB_SHORT;

    always_comb begin
        next_state = state;
        stab_start = 1'b0;
        unique case (state)
            hpm_pkg::HPM_RUN: begin
                if (stop_exec) begin
                    // RQ7: pending wakes at once
                    if (irq_pend_sync2) begin
                        next_state = hpm_pkg::HPM_RESUME;
                    // RQ1: clocked stop
                    end else if (osc_irq_enable) begin
                        next_state = hpm_pkg::HPM_ACTIVE_STOP;
                    // RQ2: full stop
                    end else begin
                        next_state = hpm_pkg::HPM_FULL_STOP;
                    end
                end
            end
            hpm_pkg::HPM_ACTIVE_STOP: begin
                // RQ5: reset applies wait
                if (rst_sync2) begin
                    next_state = hpm_pkg::HPM_STABILISE;
                    stab_start = 1'b1;
                // RQ3: only counter wakes
                end else if (rt_sync2) begin
                    // RQ4: no wait
                    next_state = hpm_pkg::HPM_RESUME;
                // RQ10: enable cleared falls to full stop
                end else if (!osc_irq_enable) begin
                    next_state = hpm_pkg::HPM_FULL_STOP;
                end
            end
            hpm_pkg::HPM_FULL_STOP: begin
                // RQ12: reset or designated sources
                // RQ13: restart oscillator and wait
                if (rst_sync2 || wake_sync2) begin
                    next_state = hpm_pkg::HPM_STABILISE;
                    stab_start = 1'b1;
                end
            end
            hpm_pkg::HPM_STABILISE: begin
                if (stab_done) begin
                    next_state = hpm_pkg::HPM_RESUME;
                end
            end
            hpm_pkg::HPM_RESUME: begin
                next_state = hpm_pkg::HPM_RUN;
            end
            default: next_state = hpm_pkg::HPM_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= hpm_pkg::HPM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // RQ21: reset wins over interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_cause <= hpm_pkg::HPM_WAKE_NONE;
        end else if (state == hpm_pkg::HPM_RUN) begin
            wake_cause <= stop_exec ? hpm_pkg::HPM_WAKE_IRQ : hpm_pkg::HPM_WAKE_NONE;
        end else if ((state == hpm_pkg::HPM_ACTIVE_STOP || state == hpm_pkg::HPM_FULL_STOP) && rst_sync2) begin
            wake_cause <= hpm_pkg::HPM_WAKE_RESET;
        end
    end

    hpm_stab_timer #(
        .WIDTH(13)
    ) u_stab (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(stab_start),
        .length(stab_len),
        .busy(stab_busy),
        .done(stab_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Gating outputs; the oscillator itself stays on in clocked stop.
    always_comb begin
        cpu_halt = (state != hpm_pkg::HPM_RUN) && (state != hpm_pkg::HPM_RESUME);
        // RQ15: oscillator off in full stop
        osc_enable = (state != hpm_pkg::HPM_FULL_STOP);
        // RQ8: only counter clocked
        rt_counter_clk_en = (state != hpm_pkg::HPM_FULL_STOP);
        periph_clk_en = !cpu_halt;
    end

    // RQ14: resume path
    assign resume_irq = (state == hpm_pkg::HPM_RESUME) && (wake_cause != hpm_pkg::HPM_WAKE_RESET);
    assign resume_reset_vector = (state == hpm_pkg::HPM_RESUME) && (wake_cause == hpm_pkg::HPM_WAKE_RESET);

    // RQ16: full stop watchdog option
    // RQ9: clocked stop exempt
    assign watchdog_reset = (state == hpm_pkg::HPM_RUN) && stop_exec && !irq_pend_sync2 && !osc_irq_enable
        && wdg_enabled && !watchdog_in_stop_option;

    ////////////////////////////////////////////////////////////////////////
    // Priority mask handling; a push saves the current code first.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_force <= 1'b0;
            cc_force_value <= 8'h00;
            cc_push <= 1'b0;
            irq_priority_mask <= `HPM_IMASK_RESET;
            cc_shadow <= 8'h00;
        end else begin
            cc_force <= 1'b0;
            cc_push <= 1'b0;
            if (state == hpm_pkg::HPM_RUN && stop_exec) begin
                // RQ6: force mask to 10
                cc_force <= 1'b1;
                cc_force_value <= {condition_code_reg[7:6], IMASK_STOP[1], condition_code_reg[4], IMASK_STOP[0],
                    condition_code_reg[2:0]};
                irq_priority_mask <= IMASK_STOP;
            end else if (irq_taken) begin
                // RQ17: push then set level
                cc_push <= 1'b1;
                cc_shadow <= condition_code_reg;
                irq_priority_mask <= irq_level;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY.
    assign bus_ok = (haddr[31:`HPM_ADDR_W] == '0) && (hsize == `HPM_HSIZE_WORD);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            a_reg <= '0;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite && bus_ok;
            a_reg <= haddr[`HPM_ADDR_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_clock_status_reg <= 8'h00;
        end else if (wr_pend && ({28'h0, a_reg} == `HPM_A_CTRL)) begin
            main_clock_status_reg <= hwdata[7:0];
        end
    end

    assign osc_irq_enable = main_clock_status_reg[`HPM_CTRL_OIE];
    assign long_stab = main_clock_status_reg[`HPM_CTRL_LONG];
    assign watchdog_in_stop_option = main_clock_status_reg[`HPM_CTRL_WDGS];
    assign wdg_enabled = main_clock_status_reg[`HPM_CTRL_WDGEN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite && bus_ok) begin
                unique case (haddr)
                    `HPM_A_CTRL: hrdata <= {24'h0, main_clock_status_reg};
                    `HPM_A_STATUS: hrdata <= {26'h0, stab_busy, wake_cause, state};
                    `HPM_A_CCR: hrdata <= {22'h0, irq_priority_mask, cc_shadow};
                    `HPM_A_IRQ: hrdata <= {29'h0, rst_sync2, wake_sync2, rt_sync2};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    property p_rq1;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_RUN && stop_exec && !irq_pend_sync2 && osc_irq_enable)
            |=> state == hpm_pkg::HPM_ACTIVE_STOP;
    endproperty
    a_rq1: assert property (p_rq1) else $error("clocked stop not entered"); // RQ1

    property p_rq2;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_RUN && stop_exec && !irq_pend_sync2 && !osc_irq_enable)
            |=> state == hpm_pkg::HPM_FULL_STOP && !osc_enable;
    endproperty
    a_rq2: assert property (p_rq2) else $error("full stop not entered"); // RQ2

    property p_rq3;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_ACTIVE_STOP && !rst_sync2 && !rt_sync2 && osc_irq_enable)
            |=> state == hpm_pkg::HPM_ACTIVE_STOP;
    endproperty
    a_rq3: assert property (p_rq3) else $error("clocked stop left early"); // RQ3

    property p_rq4;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_ACTIVE_STOP && rt_sync2 && !rst_sync2) |=> ##0 resume_irq;
    endproperty
    a_rq4: assert property (p_rq4) else $error("counter wake delayed"); // RQ4

    property p_rq6;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_RUN && stop_exec) |=> cc_force && irq_priority_mask == `HPM_IMASK_STOP;
    endproperty
    a_rq6: assert property (p_rq6) else $error("mask not forced"); // RQ6

    property p_rq13;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_FULL_STOP && wake_sync2 && !long_stab)
            |=> (state == hpm_pkg::HPM_STABILISE && osc_enable)[*8] ##[240:260] state == hpm_pkg::HPM_RESUME;
    endproperty
    a_rq13: assert property (p_rq13) else $error("stabilise wait wrong"); // RQ13

    property p_rq16;
        @(posedge hclk) disable iff (!hresetn)
        watchdog_reset |-> !osc_irq_enable && !watchdog_in_stop_option && wdg_enabled;
    endproperty
    a_rq16: assert property (p_rq16) else $error("bad watchdog reset"); // RQ16

    property p_rq21;
        @(posedge hclk) disable iff (!hresetn)
        (state == hpm_pkg::HPM_FULL_STOP && rst_sync2 && wake_sync2)
            |=> wake_cause == hpm_pkg::HPM_WAKE_RESET;
    endproperty
    a_rq21: assert property (p_rq21) else $error("reset lost priority"); // RQ21

    c_active: cover property (@(posedge hclk) state == hpm_pkg::HPM_ACTIVE_STOP ##1 resume_irq);
    c_full: cover property (@(posedge hclk) state == hpm_pkg::HPM_STABILISE ##1 resume_irq);
    c_reset: cover property (@(posedge hclk) resume_reset_vector);
endmodule

// ==== sim/hpm_cpu_model.sv ====
// CPU core model: executes opcodes and services the waking interrupt.
module hpm_cpu_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cc_force,
    input wire logic [7:0] cc_force_value,
    input wire logic resume_irq,
    output logic [7:0] opcode,
    output logic opcode_valid,
    output logic [7:0] condition_code_reg,
    output logic [1:0] irq_level,
    output logic irq_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        opcode = 8'h00;
        opcode_valid = 1'b0;
        irq_level = 2'h1;
    end
    ////////////////////////////////////////////////////////////////
    // The opcode means nothing without valid, so it is scrambled afterwards.
    task automatic run_op(input logic [7:0] opc);
        @(posedge hclk);
        opcode <= opc;
        opcode_valid <= 1'b1;
        @(posedge hclk);
        opcode <= ~opc;
        opcode_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // condition code register keeps forced value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            condition_code_reg <= 8'h28;
        else if (cc_force)
            condition_code_reg <= cc_force_value;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_taken <= 1'b0;
        else
            irq_taken <= resume_irq;
    end
endmodule

// ==== sim/halt_power_mode_control_tb.sv ====
module halt_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic rt_irq = 1'b0;
    logic wk_irq = 1'b0;
    logic oth_irq = 1'b0;
    logic rst_req = 1'b0;
    logic hreadyout, hresp, opcode_valid, irq_taken, cpu_halt, osc_enable, rt_counter_clk_en;
    logic periph_clk_en, cc_force, cc_push, resume_irq, resume_reset_vector, watchdog_reset;
    logic [31:0] hrdata;
    logic [7:0] opcode, condition_code_reg, cc_force_value, cc_seen;
    logic [1:0] irq_level, irq_priority_mask;
    logic wdg_seen = 1'b0;
    logic push_seen = 1'b0;
    logic [31:0] seed = 32'h0000_005c;
    int fail_count = 0;
    int comparisons = 0;
    always #50 hclk = ~hclk;
    hpm_ctrl hpm_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .opcode, .opcode_valid,
        .rt_counter_irq(rt_irq), .wake_irq(wk_irq), .other_irq(oth_irq), .wake_reset_req(rst_req),
        .condition_code_reg, .irq_level, .irq_taken, .cpu_halt, .osc_enable, .rt_counter_clk_en,
        .periph_clk_en, .cc_force, .cc_force_value, .cc_push, .irq_priority_mask, .resume_irq,
        .resume_reset_vector, .watchdog_reset);
    hpm_cpu_model cpu_i (.hclk, .hresetn, .cc_force, .cc_force_value, .resume_irq, .opcode,
        .opcode_valid, .condition_code_reg, .irq_level, .irq_taken);
    always @(posedge hclk) begin
        if (watchdog_reset === 1'b1)
            wdg_seen <= 1'b1;
        if (cc_force === 1'b1)
            cc_seen <= cc_force_value;
        if (cc_push === 1'b1)
            push_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Only a counter wake from clocked stop skips the oscillator wait.
    function automatic int exp_wait(input logic [3:0] c, input int w);
        return (c[0] && w == 0) ? 0 : (c[1] ? 4096 : 256);
    endfunction
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, lo);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_resume(input int lim, output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (resume_irq !== 1'b1 && resume_reset_vector !== 1'b1 && n < lim);
    endtask
    ////////////////////////////////////////////////////////////////
    // w: 0 counter irq, 1 wake irq, 2 reset, 3 reset with wake irq.
    task automatic stop_wake(input logic [3:0] c, input int w);
        logic [31:0] q;
        int n;
        ahb(1'b1, 32'h0, {28'h0, c}, q);
        wdg_seen = 1'b0;
        push_seen = 1'b0;
        cc_seen = 8'h00;
        cpu_i.run_op(8'h8e);
        repeat (3) @(posedge hclk);
        check_bit(cpu_halt, 1'b1);
        check_bit(osc_enable, c[0]);
        check_bit(rt_counter_clk_en, c[0]);
        check_bit(periph_clk_en, 1'b0);
        check_word({24'h0, cc_seen & 8'h28}, 32'h20);
        check_bit(wdg_seen, c[3] & ~c[0] & ~c[2]);
        ahb(1'b0, 32'h4, 32'h0, q);
        check_word(q & 32'h7, c[0] ? 32'h1 : 32'h2);
        oth_irq <= 1'b1;
        wk_irq <= c[0];
        repeat (6) @(posedge hclk);
        check_bit(cpu_halt, 1'b1);
        oth_irq <= 1'b0;
        wk_irq <= 1'b0;
        repeat (4) @(posedge hclk);
        rt_irq <= (w == 0);
        wk_irq <= w[0];
        rst_req <= w[1];
        wait_resume(5000, n);
        rt_irq <= 1'b0;
        wk_irq <= 1'b0;
        rst_req <= 1'b0;
        check_bit(resume_reset_vector, w[1]);
        check_range(n, exp_wait(c, w), exp_wait(c, w) + 8);
        repeat (4) @(posedge hclk);
        check_bit(cpu_halt, 1'b0);
        check_bit(push_seen, ~w[1]);
        check_word({30'h0, irq_priority_mask}, w[1] ? 32'h2 : 32'h1);
        $display("stop test ctrl %h wake %0d done", c, w);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        int w;
        int n;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_bit(cpu_halt, 1'b0);
        check_bit(osc_enable, 1'b1);
        check_word({30'h0, irq_priority_mask}, 32'h3);
        ahb(1'b1, 32'h10, 32'hff, r);
        ahb(1'b0, 32'h10, 32'h0, r);
        check_word(r, 32'h0);
        ahb(1'b0, 32'h0, 32'h0, r);
        check_word(r, 32'h0);
        check_bit(hresp, 1'b0);
        $display("reset test done");
        stop_wake(4'h1, 0);
        stop_wake(4'h3, 2);
        stop_wake(4'h8, 3);
        stop_wake(4'h2, 1);
        stop_wake(4'h9, 0);
        repeat (6) begin
            r = rnd();
            w = int'(r[5:4]);
            if (!r[0] && w == 0)
                w = 1;
            if (r[0] && w == 1)
                w = 0;
            stop_wake(r[3:0], w);
        end
        ahb(1'b1, 32'h0, 32'h0, r);
        oth_irq <= 1'b1;
        repeat (3) @(posedge hclk);
        cpu_i.run_op(8'h8e);
        wait_resume(20, n);
        oth_irq <= 1'b0;
        check_range(n, 0, 10);
        $display("pending test done");
        r = rnd();
        cpu_i.run_op(r[7:0] == 8'h8e ? 8'h9d : r[7:0]);
        repeat (3) @(posedge hclk);
        check_bit(cpu_halt, 1'b0);
        $display("opcode test done");
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        fail_count++;
        wrap_up();
    end
endmodule
